// File: hdl/lcgs_map.svh
// offsets, field positions and reset values of the logic cell gate select block
// assumes: included by lcgs_top, the checker and the testbench; register index times four gives the byte address
`ifndef LCGS_MAP_SVH
`define LCGS_MAP_SVH

// =====================================================================
// register indices
`define LCGS_IDX_CON     16'h068C
`define LCGS_IDX_POL     16'h068D
`define LCGS_IDX_SEL0    16'h068E
`define LCGS_IDX_SEL1    16'h068F
`define LCGS_IDX_SEL2    16'h0690
`define LCGS_IDX_SEL3    16'h0691
`define LCGS_IDX_GLS0    16'h0692
`define LCGS_IDX_GLS1    16'h0693
`define LCGS_IDX_GLS2    16'h0694
`define LCGS_IDX_GLS3    16'h0695
`define LCGS_IDX_INST    16'h0696
`define LCGS_IDX_MIRROR  16'h0697

// =====================================================================
// field positions
`define LCGS_CON_EN      7
`define LCGS_CON_OUT     5
`define LCGS_CON_INTP    4
`define LCGS_CON_INTN    3
`define LCGS_POL_OUT     7
`define LCGS_SEL_W       7
`define LCGS_INST_W      4

// =====================================================================
// reset values
`define LCGS_RST_BYTE    8'h00
`define LCGS_RST_INST    4'h0
`define LCGS_RST_MIRROR  4'h0

`endif

// File: hdl/lcgs_pkg.sv
// types shared by the logic cell gate select block
// assumes: compiled before lcgs_top
package lcgs_pkg;

  // =====================================================================
  // cell function modes
  typedef enum logic [2:0] {
    MODE_AND_OR = 3'b000,
    MODE_OR_XOR = 3'b001,
    MODE_AND4 = 3'b010,
    MODE_SR_LATCH = 3'b011,
    MODE_DFF_SR = 3'b100,
    MODE_DFF2_R = 3'b101,
    MODE_JKFF_R = 3'b110,
    MODE_DLATCH_SR = 3'b111
  } lcgs_mode_e;

  // =====================================================================
  // decoded register targets
  typedef enum logic [3:0] {
    REG_CON = 4'b0000,
    REG_POL = 4'b0001,
    REG_SEL0 = 4'b0010,
    REG_SEL1 = 4'b0011,
    REG_SEL2 = 4'b0100,
    REG_SEL3 = 4'b0101,
    REG_GLS0 = 4'b0110,
    REG_GLS1 = 4'b0111,
    REG_GLS2 = 4'b1000,
    REG_GLS3 = 4'b1001,
    REG_INST = 4'b1010,
    REG_MIRROR = 4'b1011,
    REG_NONE = 4'b1111
  } lcgs_reg_e;

  // =====================================================================
  // one cell's register bank
  typedef struct packed {
    logic [7:0] con;
    logic [7:0] pol;
    logic [3:0][6:0] sel;
    logic [3:0][7:0] gls;
  } lcgs_bank_s;

  // =====================================================================
  // apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } lcgs_apb_req_s;

endpackage

// File: hdl/lcgs_top.sv
// four configurable logic cells with register-programmed input gating, apb slave
// assumes: one clock core_clk, synchronous active-high rst acting as power-on reset,
// source signals arrive asynchronously and are synchronised here
//
// Summary of operation
// [RULE1] seven-bit field picks data input four source
// [RULE2] odd term bit gates true data into gate1
// [RULE3] even term bit gates inverted data into gate1
// [RULE4] gates two to four use own registers
// [RULE5] term bits set on power reset only
// [RULE6] mirror register shows four cell outputs
// [RULE7] gate polarity bit inverts gate output
// [RULE8] three-bit mode picks cell function
// [RULE9] gate is OR of terms, empty gives zero
`timescale 1ns/1ps

`include "lcgs_map.svh"

module lcgs_top
  import lcgs_pkg::*;
#(
  parameter int NUM_CELLS = 4,
  parameter int SRC_W = 128
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SRC_W-1:0] srcIn,
  output logic [NUM_CELLS-1:0] cellOutputSignal
);

  // =====================================================================
  // decode helpers
  function automatic lcgs_reg_e regDecode(input logic [15:0] byteAddr);
    logic [13:0] idx;
    lcgs_reg_e r;
    idx = byteAddr[15:2];
    r = REG_NONE;
    if (byteAddr[1:0] == 2'b00) begin
      unique case (idx)
        14'(`LCGS_IDX_CON): r = REG_CON;
        14'(`LCGS_IDX_POL): r = REG_POL;
        14'(`LCGS_IDX_SEL0): r = REG_SEL0;
        14'(`LCGS_IDX_SEL1): r = REG_SEL1;
        14'(`LCGS_IDX_SEL2): r = REG_SEL2;
        14'(`LCGS_IDX_SEL3): r = REG_SEL3;
        14'(`LCGS_IDX_GLS0): r = REG_GLS0;
        14'(`LCGS_IDX_GLS1): r = REG_GLS1;
        14'(`LCGS_IDX_GLS2): r = REG_GLS2;
        14'(`LCGS_IDX_GLS3): r = REG_GLS3;
        14'(`LCGS_IDX_INST): r = REG_INST;
        14'(`LCGS_IDX_MIRROR): r = REG_MIRROR;
        default: r = REG_NONE;
      endcase
    end
    return r;
  endfunction

  // OR of enabled true and inverted terms, then gate polarity
  function automatic logic gateEval(input logic [7:0] terms, input logic [3:0] data, input logic inv);
    logic acc;
    acc = 1'b0;
    for (int y = 0; y < 4; y++) begin
      acc = acc | (terms[2*y+1] & data[y]); // [RULE2] [RULE4] [RULE9]
      acc = acc | (terms[2*y] & ~data[y]); // [RULE3] [RULE4] [RULE9]
    end
    return acc ^ inv; // [RULE7]
  endfunction

  // =====================================================================
  // apb slave
  lcgs_apb_req_s req;
  lcgs_reg_e regHit;
  logic setupPhase;
  logic writeTaken;
  logic instValid;
  logic [1:0] instIdx;
  logic [3:0] instSelectQ;
  logic [31:0] prdataQ;
  logic errQ;
  lcgs_bank_s bankQ [NUM_CELLS];
  logic [NUM_CELLS-1:0] cellOutQ;
  logic [NUM_CELLS-1:0] rawOut;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign regHit = regDecode(req.addr);
  assign setupPhase = req.sel & ~req.enable;
  assign writeTaken = req.sel & req.enable & req.write & ~errQ;
  assign instValid = 32'(instSelectQ) < NUM_CELLS;
  assign instIdx = instSelectQ[1:0];
  assign pready = 1'b1;
  assign pslverr = req.sel & req.enable & errQ;
  assign prdata = prdataQ;

  // read data and error are fixed during the setup cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdataQ <= 32'h0000_0000;
      errQ <= 1'b0;
    end else if (setupPhase) begin
      errQ <= (regHit == REG_NONE);
      prdataQ <= 32'h0000_0000;
      if (regHit == REG_INST) begin
        prdataQ <= {28'h000_0000, instSelectQ};
      end else if (regHit == REG_MIRROR) begin
        prdataQ <= {{(32-NUM_CELLS){1'b0}}, cellOutQ}; // [RULE6]
      end else if (instValid) begin
        unique case (regHit)
          REG_CON: prdataQ <= {24'h00_0000, bankQ[instIdx].con[7:6], cellOutQ[instIdx],
                               bankQ[instIdx].con[4:0]};
          REG_POL: prdataQ <= {24'h00_0000, bankQ[instIdx].pol};
          REG_SEL0: prdataQ <= {25'h000_0000, bankQ[instIdx].sel[0]};
          REG_SEL1: prdataQ <= {25'h000_0000, bankQ[instIdx].sel[1]};
          REG_SEL2: prdataQ <= {25'h000_0000, bankQ[instIdx].sel[2]};
          REG_SEL3: prdataQ <= {25'h000_0000, bankQ[instIdx].sel[3]}; // [RULE1]
          REG_GLS0: prdataQ <= {24'h00_0000, bankQ[instIdx].gls[0]};
          REG_GLS1: prdataQ <= {24'h00_0000, bankQ[instIdx].gls[1]};
          REG_GLS2: prdataQ <= {24'h00_0000, bankQ[instIdx].gls[2]};
          REG_GLS3: prdataQ <= {24'h00_0000, bankQ[instIdx].gls[3]};
          default: prdataQ <= 32'h0000_0000;
        endcase
      end
    end
  end

  // instance select register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      instSelectQ <= `LCGS_RST_INST;
    end else if (writeTaken && regHit == REG_INST) begin
      instSelectQ <= req.wdata[`LCGS_INST_W-1:0];
    end
  end

  // =====================================================================
  // source synchroniser
  logic [SRC_W-1:0] srcMetaQ;
  logic [SRC_W-1:0] srcSyncQ;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      srcMetaQ <= '0;
      srcSyncQ <= '0;
    end else begin
      srcMetaQ <= srcIn;
      srcSyncQ <= srcMetaQ;
    end
  end

  // =====================================================================
  // per-cell banks and cell logic
  genvar c;
  generate
    for (c = 0; c < NUM_CELLS; c++) begin : gCell
      logic bankWr;
      logic [3:0] dataIn;
      logic [3:0] gate;
      logic stateQ;
      logic g1PrevQ;
      logic g1Rise;
      logic combOut;
      lcgs_mode_e mode;

      assign bankWr = writeTaken & instValid & (32'(instIdx) == c);

      // register bank, cleared only by power reset
      always_ff @(posedge core_clk) begin
        if (rst) begin
          bankQ[c].con <= `LCGS_RST_BYTE;
          bankQ[c].pol <= `LCGS_RST_BYTE;
          bankQ[c].sel <= '0;
          bankQ[c].gls <= '0; // [RULE5]
        end else if (bankWr) begin
          unique case (regHit)
            REG_CON: bankQ[c].con <= {req.wdata[7:6], 1'b0, req.wdata[4:0]};
            REG_POL: bankQ[c].pol <= {req.wdata[7], 3'b000, req.wdata[3:0]};
            REG_SEL0: bankQ[c].sel[0] <= req.wdata[`LCGS_SEL_W-1:0];
            REG_SEL1: bankQ[c].sel[1] <= req.wdata[`LCGS_SEL_W-1:0];
            REG_SEL2: bankQ[c].sel[2] <= req.wdata[`LCGS_SEL_W-1:0];
            REG_SEL3: bankQ[c].sel[3] <= req.wdata[`LCGS_SEL_W-1:0]; // [RULE1]
            REG_GLS0: bankQ[c].gls[0] <= req.wdata[7:0]; // [RULE2] [RULE3]
            REG_GLS1: bankQ[c].gls[1] <= req.wdata[7:0]; // [RULE4]
            REG_GLS2: bankQ[c].gls[2] <= req.wdata[7:0]; // [RULE4]
            REG_GLS3: bankQ[c].gls[3] <= req.wdata[7:0]; // [RULE4]
            default: bankQ[c].con <= bankQ[c].con;
          endcase
        end
      end

      // data input selection, same encoding for all four
      for (genvar y = 0; y < 4; y++) begin : gData
        assign dataIn[y] = srcSyncQ[bankQ[c].sel[y]]; // [RULE1]
      end

      // four gates
      for (genvar g = 0; g < 4; g++) begin : gGate
        assign gate[g] = gateEval(bankQ[c].gls[g], dataIn, bankQ[c].pol[g]); // [RULE4] [RULE7]
      end

      assign mode = lcgs_mode_e'(bankQ[c].con[2:0]);
      assign g1Rise = gate[0] & ~g1PrevQ;

      always_ff @(posedge core_clk) begin
        if (rst) begin
          g1PrevQ <= 1'b0;
        end else begin
          g1PrevQ <= gate[0];
        end
      end

      // storage modes, reset dominates set except in MODE_SR_LATCH, where set wins
      always_ff @(posedge core_clk) begin
        if (rst) begin
          stateQ <= 1'b0;
        end else begin
          unique case (mode)
            MODE_SR_LATCH: begin
              if (gate[0] | gate[1]) begin
                stateQ <= 1'b1; // [RULE8]
              end else if (gate[2] | gate[3]) begin
                stateQ <= 1'b0;
              end
            end
            MODE_DFF_SR: begin
              if (gate[2]) begin
                stateQ <= 1'b0;
              end else if (gate[3]) begin
                stateQ <= 1'b1;
              end else if (g1Rise) begin
                stateQ <= gate[1]; // [RULE8]
              end
            end
            MODE_DFF2_R: begin
              if (gate[2]) begin
                stateQ <= 1'b0;
              end else if (g1Rise) begin
                stateQ <= gate[1] & gate[3]; // [RULE8]
              end
            end
            MODE_JKFF_R: begin
              if (gate[2]) begin
                stateQ <= 1'b0;
              end else if (g1Rise) begin
                unique case ({gate[1], gate[3]})
                  2'b10: stateQ <= 1'b1;
                  2'b01: stateQ <= 1'b0;
                  2'b11: stateQ <= ~stateQ; // [RULE8]
                  default: stateQ <= stateQ;
                endcase
              end
            end
            MODE_DLATCH_SR: begin
              if (gate[2]) begin
                stateQ <= 1'b0;
              end else if (gate[3]) begin
                stateQ <= 1'b1;
              end else if (gate[0]) begin
                stateQ <= gate[1]; // [RULE8]
              end
            end
            default: stateQ <= stateQ;
          endcase
        end
      end

      // combinational modes
      always_comb begin
        unique case (mode)
          MODE_AND_OR: combOut = (gate[0] & gate[1]) | (gate[2] & gate[3]); // [RULE8]
          MODE_OR_XOR: combOut = (gate[0] | gate[1]) ^ (gate[2] | gate[3]); // [RULE8]
          MODE_AND4: combOut = &gate; // [RULE8]
          default: combOut = stateQ;
        endcase
      end

      assign rawOut[c] = bankQ[c].con[`LCGS_CON_EN] & (combOut ^ bankQ[c].pol[`LCGS_POL_OUT]);

      // registered cell output, also the mirror bit
      always_ff @(posedge core_clk) begin
        if (rst) begin
          cellOutQ[c] <= 1'(`LCGS_RST_MIRROR >> c); // [RULE6]
        end else begin
          cellOutQ[c] <= rawOut[c]; // [RULE6]
        end
      end
    end
  endgenerate

  assign cellOutputSignal = cellOutQ;

endmodule

// File: tb/lcgs_top_assertions.sv
// checker for the apb and cell output ports of lcgs_top
// assumes: bound onto lcgs_top, map header on the include path
`timescale 1ns/1ps
`include "lcgs_map.svh"
module lcgs_top_chk #(
  parameter int NUM_CELLS = 4,
  parameter int SRC_W = 128
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [SRC_W-1:0] srcIn,
  input wire logic [NUM_CELLS-1:0] cellOutputSignal
);
  // ====
  // address decode
  localparam logic [15:0] LO = `LCGS_IDX_CON << 2;
  localparam logic [15:0] HI = `LCGS_IDX_MIRROR << 2;
  wire logic acc = psel && penable;
  wire logic bad = paddr < LO || paddr > HI || paddr[1:0] != 2'b00;
  default clocking cb @(posedge core_clk);
  endclocking
  // ====
  // sequences
  sequence mirSetup;
    psel && !penable && !pwrite && paddr == HI;
  endsequence
  sequence accDone;
    acc && pready;
  endsequence
  // ====
  // assertions
  chk_reset_clear: assert property (rst |=> prdata == 32'h0000_0000 && cellOutputSignal == '0 && !pslverr)
    else $error("outputs not cleared by reset");
  chk_ready_high: assert property (disable iff (rst) acc |-> pready)
    else $error("pready low in access phase");
  chk_slverr_phase: assert property (disable iff (rst) pslverr |-> acc)
    else $error("pslverr outside access phase");
  chk_unmapped_err: assert property (disable iff (rst) acc && bad |-> pslverr)
    else $error("no error on unmapped address");
  chk_mapped_ok: assert property (disable iff (rst) acc && !bad |-> !pslverr)
    else $error("error on mapped address");
  chk_err_rdata: assert property (disable iff (rst) acc && pslverr |-> prdata == 32'h0000_0000)
    else $error("read data not zero on error");
  chk_rdata_hold: assert property (disable iff (rst) accDone |=> $stable(prdata))
    else $error("read data changed after access");
  chk_mirror_read: assert property (disable iff (rst) mirSetup |=>
    prdata == {{(32-NUM_CELLS){1'b0}}, $past(cellOutputSignal)})
    else $error("mirror read differs from outputs");
endmodule

bind lcgs_top lcgs_top_chk #(.NUM_CELLS(NUM_CELLS), .SRC_W(SRC_W)) u_lcgs_top_chk (
  .core_clk(core_clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .srcIn(srcIn),
  .cellOutputSignal(cellOutputSignal)
);

// File: tb/testbench.sv
// self-checking bench for lcgs_top over apb
// assumes: design and checker compiled first, map header on include path
`timescale 1ns/1ps
`include "lcgs_map.svh"
module testbench import lcgs_pkg::*; ;
  typedef struct packed {
    logic [15:0] idx;
    logic [7:0] w;
    logic [7:0] r;
    logic e;
  } lcgs_row_s;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [127:0] srcIn = '0;
  logic [127:0] v;
  logic [31:0] rd;
  logic er;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic [3:0] cellOutputSignal;
  int errTotal = 0;
  int compares = 0;
  logic [6:0] src [4] = '{7'h00, 7'h21, 7'h40, 7'h7F};
  lcgs_row_s rows [9] = '{
    '{`LCGS_IDX_CON, 8'h1F, 8'h1F, 1'b0},
    '{`LCGS_IDX_POL, 8'hFF, 8'h8F, 1'b0},
    '{`LCGS_IDX_SEL3, 8'hFF, 8'h7F, 1'b0},
    '{`LCGS_IDX_GLS0, 8'hA5, 8'hA5, 1'b0},
    '{`LCGS_IDX_GLS1, 8'h5A, 8'h5A, 1'b0},
    '{`LCGS_IDX_GLS2, 8'hC3, 8'hC3, 1'b0},
    '{`LCGS_IDX_GLS3, 8'h3C, 8'h3C, 1'b0},
    '{`LCGS_IDX_MIRROR, 8'hFF, 8'h00, 1'b0},
    '{16'h068B, 8'hFF, 8'h00, 1'b1}
  };
  // storage mode steps: mode[7:5], gate polarity[4:1], expected output[0]
  logic [7:0] seqRows [23] = '{
    8'h68, 8'h6B, 8'h61, 8'h70, 8'h98, 8'h91, 8'h88, 8'h84,
    8'h87, 8'h81, 8'hD1, 8'hD2, 8'hD4, 8'hD7, 8'hE7, 8'hE2,
    8'hE0, 8'hE4, 8'hB7, 8'hA5, 8'hA6, 8'hB4, 8'hB7
  };

  lcgs_top u_lcgs_top (
    .core_clk(core_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .srcIn(srcIn),
    .cellOutputSignal(cellOutputSignal)
  );

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // ====
  // helpers
  function automatic logic [15:0] ba(input int i);
    return 16'(i * 4);
  endfunction
  function automatic logic mexp(input int m, input logic [3:0] g);
    case (m)
      0: return (g[0] & g[1]) | (g[2] & g[3]);
      1: return (g[0] | g[1]) ^ (g[2] | g[3]);
      default: return &g;
    endcase
  endfunction
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    errTotal++;
    test_done;
  end

  // ====
  // tests
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      apb(1'b1, ba(rows[i].idx), rows[i].w);
      apb(1'b0, ba(rows[i].idx), 8'h00);
      chk(rd, {24'h00_0000, rows[i].r});
      chk({31'h0000_0000, er}, {31'h0000_0000, rows[i].e});
    end
    apb(1'b1, ba(`LCGS_IDX_INST), 8'h04);
    apb(1'b1, ba(`LCGS_IDX_GLS0), 8'hFF);
    apb(1'b0, ba(`LCGS_IDX_GLS0), 8'h00);
    chk(rd, 32'h0000_0000);
    apb(1'b1, ba(`LCGS_IDX_INST), 8'h01);
    apb(1'b0, ba(`LCGS_IDX_GLS0), 8'h00);
    chk(rd, 32'h0000_0000);
    apb(1'b1, ba(`LCGS_IDX_INST), 8'h00);
    apb(1'b0, ba(`LCGS_IDX_GLS0), 8'h00);
    chk(rd, 32'h0000_00A5);
    $display("register test done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ba(`LCGS_IDX_GLS0 + k), 8'h00);
      apb(1'b1, ba(`LCGS_IDX_SEL0 + k), {1'b0, src[k]});
    end
    for (int m = 0; m < 3; m++) begin
      for (int g = 0; g < 16; g++) begin
        apb(1'b1, ba(`LCGS_IDX_POL), 8'(g));
        apb(1'b1, ba(`LCGS_IDX_CON), 8'(8'h80 + m));
        repeat (3) @(posedge core_clk);
        apb(1'b0, ba(`LCGS_IDX_MIRROR), 8'h00);
        chk(rd, {31'h0000_0000, mexp(m, 4'(g))});
      end
    end
    $display("mode test done");
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, ba(`LCGS_IDX_POL), 8'(15 ^ (1 << g)));
      for (int b = 0; b < 8; b++) begin
        for (int k = 0; k < 4; k++) begin
          apb(1'b1, ba(`LCGS_IDX_GLS0 + k), 8'(k == g ? 1 << b : 0));
        end
        for (int s = 5; s < 11; s += 5) begin
          v = '0;
          for (int j = 0; j < 4; j++) begin
            v[src[j]] = s[j];
          end
          srcIn <= v;
          repeat (5) @(posedge core_clk);
          chk({31'h0000_0000, cellOutputSignal[0]}, {31'h0000_0000, b[0] ? s[b >> 1] : ~s[b >> 1]});
        end
      end
    end
    $display("gate test done");
    apb(1'b1, ba(`LCGS_IDX_GLS3), 8'h00);
    foreach (seqRows[i]) begin
      apb(1'b1, ba(`LCGS_IDX_POL), {4'h0, seqRows[i][4:1]});
      apb(1'b1, ba(`LCGS_IDX_CON), {5'h10, seqRows[i][7:5]});
      repeat (3) @(posedge core_clk);
      apb(1'b0, ba(`LCGS_IDX_MIRROR), 8'h00);
      chk(rd, {31'h0000_0000, seqRows[i][0]});
    end
    $display("storage test done");
    apb(1'b1, ba(`LCGS_IDX_GLS0), 8'h3C);
    apb(1'b0, ba(`LCGS_IDX_GLS0), 8'h00);
    chk(rd, 32'h0000_003C);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk({28'h000_0000, cellOutputSignal}, 32'h0000_0000);
    apb(1'b0, ba(`LCGS_IDX_GLS0), 8'h00);
    chk(rd, 32'h0000_0000);
    apb(1'b0, ba(`LCGS_IDX_MIRROR), 8'h00);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
    test_done;
  end
endmodule
